// file: dv/mbd_core_tb.sv
// self-checking bench for the branch/interrupt/decimal slice over ahb-lite
`timescale 1ns/1ps
`include "mbd_defines.svh"
module mbd_core_tb;
	typedef struct {
		logic [7:0] st0, acc, fdat, hi;
		logic [3:0] op;
		logic       d;
		logic [8:0] adr;
		logic [7:0] e_acc, e_fdat;
		logic [9:0] e_pc;
		logic [7:0] e_st;
	} mbd_row_s;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic        global_interrupt_enable_bit;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [9:0]  pc;
	logic [31:0] haddr, hwdata, hrdata, q;
	int          err_total, n_tests;
	mbd_row_s    rows [0:14];
	assign hready = hreadyout;
	mbd_core mbd_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pc(pc),
		.global_interrupt_enable_bit(global_interrupt_enable_bit));
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task results;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// ready is looked at just before the edge, where it is settled
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		int   n;
		logic r;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		for (int p = 0; p < 2; p++) begin
			n = 0;
			do begin
				@(negedge hclk);
				r = hreadyout;
				q = hrdata;
				@(posedge hclk);
				n++;
			end while (r !== 1'b1 && n < 20);
			if (r !== 1'b1) begin
				err_total++;
				$display("[FAIL] %0t bus hang", $time);
				results();
			end else if (p == 0) begin
				htrans <= 2'h0;
				hwdata <= d;
			end
		end
	endtask
	task wr(input logic [4:0] o, input logic [31:0] d);
		xfer(1'b1, {27'h0, o}, d);
	endtask
	task rd(input logic [4:0] o);
		xfer(1'b0, {27'h0, o}, 32'h0);
	endtask
	task idle;
		int n;
		n = 0;
		do begin
			rd(`MBD_OFF_STATUS);
			n++;
		end while (q[0] !== 1'b0 && n < 20);
		if (q[0] !== 1'b0) begin
			err_total++;
			$display("[FAIL] %0t busy never cleared", $time);
			results();
		end
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
		err_total = 0;
		n_tests = 0;
		hresetn = 1'b0;
		rows[0] = '{8'h00, 8'h4D, 8'h00, 8'h00, 4'h1, 1'b0, 9'h0, 8'h53, 8'h00, 10'h0A1, 8'h10};
		rows[1] = '{8'h00, 8'hA2, 8'h00, 8'h00, 4'h1, 1'b0, 9'h0, 8'h02, 8'h00, 10'h0A1, 8'h12};
		rows[2] = '{8'h02, 8'h15, 8'h00, 8'h00, 4'h1, 1'b0, 9'h0, 8'h75, 8'h00, 10'h0A1, 8'h12};
		rows[3] = '{8'h00, 8'h9B, 8'h00, 8'h00, 4'h1, 1'b0, 9'h0, 8'h01, 8'h00, 10'h0A1, 8'h12};
		rows[4] = '{8'h00, 8'h33, 8'h05, 8'h00, 4'h2, 1'b0, 9'h0, 8'h04, 8'h05, 10'h0A1, 8'h10};
		rows[5] = '{8'h00, 8'h33, 8'h05, 8'h00, 4'h2, 1'b1, 9'h0, 8'h33, 8'h04, 10'h0A1, 8'h10};
		rows[6] = '{8'h00, 8'h33, 8'h01, 8'h00, 4'h2, 1'b1, 9'h0, 8'h33, 8'h00, 10'h0A2, 8'h28};
		rows[7] = '{8'h00, 8'h33, 8'h01, 8'h00, 4'h2, 1'b0, 9'h0, 8'h00, 8'h01, 10'h0A2, 8'h28};
		rows[8] = '{8'h06, 8'h33, 8'h05, 8'h00, 4'h3, 1'b0, 9'h0, 8'h33, 8'h05, 10'h0A1, 8'h12};
		rows[9] = '{8'h02, 8'h33, 8'h05, 8'h00, 4'h4, 1'b0, 9'h0, 8'h33, 8'h05, 10'h0A1, 8'h16};
		rows[10] = '{8'h00, 8'h33, 8'h05, 8'h02, 4'h5, 1'b0, 9'h1FF, 8'h33, 8'h05, 10'h3FF, 8'h20};
		rows[11] = '{8'h00, 8'h33, 8'h05, 8'hFD, 4'h5, 1'b0, 9'h034, 8'h33, 8'h05, 10'h034, 8'h20};
		rows[12] = '{8'h00, 8'h34, 8'h05, 8'h02, 4'h6, 1'b0, 9'h0, 8'h34, 8'h05, 10'h234, 8'h20};
		rows[13] = '{8'h00, 8'hFF, 8'h05, 8'hFD, 4'h6, 1'b0, 9'h0, 8'hFF, 8'h05, 10'h1FF, 8'h20};
		rows[14] = '{8'h00, 8'h33, 8'h05, 8'h00, 4'hF, 1'b0, 9'h0, 8'h33, 8'h05, 10'h0A1, 8'h10};
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 15; i++) begin
			wr(`MBD_OFF_STATUS, {24'h0, rows[i].st0});
			wr(`MBD_OFF_ACC, {24'h0, rows[i].acc});
			wr(`MBD_OFF_PC, 32'h0000_00A0);
			wr(`MBD_OFF_PAGEHI, {24'h0, rows[i].hi});
			wr(`MBD_OFF_TBLHI, {24'h0, rows[i].hi});
			wr(`MBD_OFF_FSEL, 32'h0000_0005);
			wr(`MBD_OFF_FDATA, {24'h0, rows[i].fdat});
			wr(`MBD_OFF_CMD, {7'h0, rows[i].adr, 2'h0, 6'h05, 3'h0, rows[i].d, rows[i].op});
			idle();
			rd(`MBD_OFF_ACC);
			chk(q, {24'h0, rows[i].e_acc});
			rd(`MBD_OFF_FDATA);
			chk(q, {24'h0, rows[i].e_fdat});
			chk({22'h0, pc}, {22'h0, rows[i].e_pc});
			rd(`MBD_OFF_STATUS);
			chk(q, {24'h0, rows[i].e_st});
			chk({31'h0, global_interrupt_enable_bit}, {31'h0, rows[i].e_st[2]});
			$display("row %0d done", i);
		end
		// a write landing while a jump is still busy must be dropped
		wr(`MBD_OFF_ACC, 32'h0000_0011);
		wr(`MBD_OFF_PAGEHI, 32'h0000_0000);
		wr(`MBD_OFF_CMD, 32'h0055_0005);
		wr(`MBD_OFF_ACC, 32'h0000_0022);
		idle();
		rd(`MBD_OFF_ACC);
		chk(q, 32'h0000_0011);
		rd(`MBD_OFF_PC);
		chk(q, 32'h0000_0055);
		$display("busy refusal done");
		rd(5'h00);
		chk(q, 32'h0);
		xfer(1'b0, 32'h0000_0020, 32'h0);
		chk({q[31:1], hresp}, 32'h0);
		$display("unmapped done");
		wr(`MBD_OFF_STATUS, 32'h0000_0004);
		hresetn <= 1'b0;
		@(negedge hclk);
		chk({21'h0, global_interrupt_enable_bit, pc}, 32'h0);
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(`MBD_OFF_ACC);
		chk(q, 32'h0);
		$display("mid-run reset done");
		results();
	end
endmodule

// file: rtl/mbd_core.sv
// execution slice: decimal adjust, decrement-skip, interrupt enable/disable, jumps; AHB-Lite regs
`timescale 1ns/1ps
`include "mbd_defines.svh"

// How it works
// RL1: decimal adjust accumulator, carry only, one cycle
// RL2: decrement register, dest 0 selects accumulator
// RL3: zero result discards next instruction, two cycles
// RL4: disable clears interrupt enable, one cycle
// RL5: enable sets global interrupt enable bit
// RL6: immediate jump loads pc[8:0], two cycles
// RL7: page high buffer bit1 goes to pc[9]
// RL8: computed jump loads pointer[1:0] to pc[9:8]
// RL9: computed jump loads accumulator into pc[7:0]
// RL10: enable takes one cycle, carry untouched, skip bit cleared
module mbd_core (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// core state
	output logic [9:0]       pc,
	output logic             global_interrupt_enable_bit
);

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic [4:0]  addr_r,   addr_nxt;
	logic        map_r,    map_nxt, wr_r, wr_nxt, rd_r, rd_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic [31:0] rd_mux;
	logic        take;
	// reads hold one wait state so a write just before is already visible
	assign take      = hsel && htrans[1] && hready;
	assign hreadyout = !rd_r;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;
	always_comb begin
		addr_nxt   = addr_r;
		map_nxt    = map_r;
		wr_nxt     = 1'b0;
		rd_nxt     = 1'b0;
		hrdata_nxt = hrdata_r;
		if (take) begin
			addr_nxt = haddr[4:0];
			map_nxt  = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
			wr_nxt   = hwrite;
			rd_nxt   = !hwrite;
		end
		if (rd_r) begin
			hrdata_nxt = rd_mux;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_r   <= 5'h00;
			map_r    <= 1'b0;
			wr_r     <= 1'b0;
			rd_r     <= 1'b0;
			hrdata_r <= `MBD_RST_WORD;
		end else begin
			addr_r   <= addr_nxt;
			map_r    <= map_nxt;
			wr_r     <= wr_nxt;
			rd_r     <= rd_nxt;
			hrdata_r <= hrdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// core state
	// ----------------------------------------------------------------
	mbd_pkg::mbd_state_e state_r, state_nxt;
	logic [3:0]  op_r,    op_nxt, cyc_r, cyc_nxt;
	logic        dest_r,  dest_nxt;
	logic [5:0]  idx_r,   idx_nxt;
	logic [8:0]  adr_r,   adr_nxt;
	logic [7:0]  acc_r,   acc_nxt;
	logic [9:0]  pc_r,    pc_nxt;
	logic        carry_r, carry_nxt, gie_r, gie_nxt, skip_r, skip_nxt;
	logic [7:0]  pagehi_r, pagehi_nxt, tblhi_r, tblhi_nxt;
	logic [5:0]  fsel_r,   fsel_nxt;
	logic [7:0]  file_r   [64], file_nxt [64];
	logic [8:0]  daa_val;
	logic        daa_c, wr_ok, exec;
	logic [7:0]  dec_val;
	assign wr_ok = wr_r && map_r && (state_r == mbd_pkg::MBD_IDLE);
	assign exec  = (state_r == mbd_pkg::MBD_EXEC);
	assign pc    = pc_r;
	assign global_interrupt_enable_bit = gie_r;
	// no half-carry is kept, so a low nibble that wrapped past 0xF is not corrected
	always_comb begin
		daa_val = {1'b0, acc_r};
		if (acc_r[3:0] > `MBD_BCD_MAX) begin
			daa_val = daa_val + `MBD_ADJ_LO;
		end
		if (carry_r || daa_val[8] || (daa_val[7:4] > `MBD_BCD_MAX)) begin
			daa_val = daa_val + `MBD_ADJ_HI;
		end
		daa_c   = carry_r || daa_val[8];
		dec_val = file_r[idx_r] - 8'h01;
	end
	always_comb begin
		state_nxt  = state_r;
		op_nxt     = op_r;
		dest_nxt   = dest_r;
		idx_nxt    = idx_r;
		adr_nxt    = adr_r;
		acc_nxt    = acc_r;
		pc_nxt     = pc_r;
		carry_nxt  = carry_r;
		gie_nxt    = gie_r;
		skip_nxt   = skip_r;
		cyc_nxt    = cyc_r;
		pagehi_nxt = pagehi_r;
		tblhi_nxt  = tblhi_r;
		fsel_nxt   = fsel_r;
		file_nxt   = file_r;
		if (wr_ok) begin
			case (addr_r)
				`MBD_OFF_CMD: begin
					op_nxt    = hwdata[`MBD_CMD_OP];
					dest_nxt  = hwdata[`MBD_CMD_DEST];
					idx_nxt   = hwdata[`MBD_CMD_IDX];
					adr_nxt   = hwdata[`MBD_CMD_ADR];
					state_nxt = mbd_pkg::MBD_EXEC;
				end
				`MBD_OFF_STATUS: begin
					carry_nxt = hwdata[`MBD_ST_CARRY];
					gie_nxt   = hwdata[`MBD_ST_GIE];
				end
				`MBD_OFF_ACC:    acc_nxt    = hwdata[7:0];
				`MBD_OFF_PC:     pc_nxt     = hwdata[9:0];
				`MBD_OFF_PAGEHI: pagehi_nxt = hwdata[7:0];
				`MBD_OFF_TBLHI:  tblhi_nxt  = hwdata[7:0];
				`MBD_OFF_FSEL:   fsel_nxt   = hwdata[5:0];
				`MBD_OFF_FDATA:  file_nxt[fsel_r] = hwdata[7:0];
				default: ;
			endcase
		end
		case (state_r)
			mbd_pkg::MBD_EXEC: begin
				state_nxt = mbd_pkg::MBD_IDLE;
				cyc_nxt   = `MBD_CYC_ONE;
				skip_nxt  = 1'b0;
				pc_nxt    = pc_r + 10'h001;
				case (op_r)
					`MBD_OP_DECADJ: begin
						acc_nxt   = daa_val[7:0]; // RL1
						carry_nxt = daa_c; // RL1
					end
					`MBD_OP_DECSKIP: begin
						if (!dest_r) begin
							acc_nxt = dec_val; // RL2
						end else begin
							file_nxt[idx_r] = dec_val; // RL2
						end
						if (dec_val == 8'h00) begin
							skip_nxt  = 1'b1; // RL3
							state_nxt = mbd_pkg::MBD_FLUSH; // RL3
						end
					end
					`MBD_OP_INTDIS: gie_nxt = 1'b0; // RL4
					`MBD_OP_INTEN:  gie_nxt = 1'b1; // RL5 RL10
					`MBD_OP_JMP: begin
						pc_nxt    = {pagehi_r[1], adr_r}; // RL6 RL7
						state_nxt = mbd_pkg::MBD_FLUSH; // RL6
					end
					`MBD_OP_CJMP: begin
						pc_nxt    = {tblhi_r[1:0], acc_r}; // RL8 RL9
						state_nxt = mbd_pkg::MBD_FLUSH; // RL8
					end
					default: ;
				endcase
			end
			mbd_pkg::MBD_FLUSH: begin
				// the fetched instruction is dropped; a skip still steps over it
				state_nxt = mbd_pkg::MBD_IDLE;
				cyc_nxt   = `MBD_CYC_TWO;
				if (skip_r) begin
					pc_nxt = pc_r + 10'h001; // RL3
				end
			end
			default: ;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r  <= mbd_pkg::MBD_IDLE;
			op_r     <= 4'h0;
			dest_r   <= 1'b0;
			idx_r    <= 6'h00;
			adr_r    <= 9'h000;
			acc_r    <= `MBD_RST_BYTE;
			pc_r     <= `MBD_RST_PC;
			carry_r  <= 1'b0;
			gie_r    <= 1'b0;
			skip_r   <= 1'b0;
			cyc_r    <= 4'h0;
			pagehi_r <= `MBD_RST_BYTE;
			tblhi_r  <= `MBD_RST_BYTE;
			fsel_r   <= 6'h00;
			for (int i = 0; i < 64; i++) begin
				file_r[i] <= `MBD_RST_BYTE;
			end
		end else begin
			state_r  <= state_nxt;
			op_r     <= op_nxt;
			dest_r   <= dest_nxt;
			idx_r    <= idx_nxt;
			adr_r    <= adr_nxt;
			acc_r    <= acc_nxt;
			pc_r     <= pc_nxt;
			carry_r  <= carry_nxt;
			gie_r    <= gie_nxt;
			skip_r   <= skip_nxt;
			cyc_r    <= cyc_nxt;
			pagehi_r <= pagehi_nxt;
			tblhi_r  <= tblhi_nxt;
			fsel_r   <= fsel_nxt;
			file_r   <= file_nxt;
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_mux = `MBD_RST_WORD;
		if (map_r) begin
			case (addr_r)
				`MBD_OFF_STATUS: begin
					rd_mux[`MBD_ST_BUSY]  = (state_r != mbd_pkg::MBD_IDLE);
					rd_mux[`MBD_ST_CARRY] = carry_r;
					rd_mux[`MBD_ST_GIE]   = gie_r;
					rd_mux[`MBD_ST_SKIP]  = skip_r;
					rd_mux[`MBD_ST_CYC]   = cyc_r;
				end
				`MBD_OFF_ACC:    rd_mux[7:0] = acc_r;
				`MBD_OFF_PC:     rd_mux[9:0] = pc_r;
				`MBD_OFF_PAGEHI: rd_mux[7:0] = pagehi_r;
				`MBD_OFF_TBLHI:  rd_mux[7:0] = tblhi_r;
				`MBD_OFF_FSEL:   rd_mux[5:0] = fsel_r;
				`MBD_OFF_FDATA:  rd_mux[7:0] = file_r[fsel_r];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	decadj_result_a: assert property ( // RL1
		exec && op_r == `MBD_OP_DECADJ |=> acc_r == $past(daa_val[7:0]) && carry_r == $past(daa_c)
		&& state_r == mbd_pkg::MBD_IDLE && cyc_r == `MBD_CYC_ONE)
		else $error("decimal adjust result or timing wrong");
	dec_dest_a: assert property ( // RL2
		exec && op_r == `MBD_OP_DECSKIP && !dest_r |=> acc_r == $past(file_r[idx_r]) - 8'h01)
		else $error("decrement to accumulator wrong");
	skip_two_a: assert property ( // RL3
		exec && op_r == `MBD_OP_DECSKIP && dec_val == 8'h00
		|=> state_r == mbd_pkg::MBD_FLUSH ##1 state_r == mbd_pkg::MBD_IDLE && cyc_r == `MBD_CYC_TWO
		&& pc_r == $past(pc_r, 2) + 10'h002)
		else $error("skip does not take two cycles");
	int_off_a: assert property ( // RL4
		exec && op_r == `MBD_OP_INTDIS |=> !gie_r && state_r == mbd_pkg::MBD_IDLE)
		else $error("disable did not clear enable");
	int_on_a: assert property ( // RL10
		exec && op_r == `MBD_OP_INTEN |=> gie_r && $stable(carry_r) && state_r == mbd_pkg::MBD_IDLE)
		else $error("enable wrong");
	jump_imm_a: assert property ( // RL7
		exec && op_r == `MBD_OP_JMP |=> pc_r == {$past(pagehi_r[1]), $past(adr_r)}
		##1 state_r == mbd_pkg::MBD_IDLE && $stable(pc_r))
		else $error("immediate jump target wrong");
	jump_comp_a: assert property ( // RL9
		exec && op_r == `MBD_OP_CJMP |=> pc_r == {$past(tblhi_r[1:0]), $past(acc_r)}
		##1 state_r == mbd_pkg::MBD_IDLE)
		else $error("computed jump target wrong");
	read_wait_a: assert property (
		take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	skip_seen_c:  cover property (exec && op_r == `MBD_OP_DECSKIP && dec_val == 8'h00);
	jump_seen_c:  cover property (exec && op_r == `MBD_OP_JMP);
	cjump_seen_c: cover property (exec && op_r == `MBD_OP_CJMP);
	daa_carry_c:  cover property (exec && op_r == `MBD_OP_DECADJ && daa_c);
endmodule

// file: rtl/mbd_defines.svh
// register map, command fields and arithmetic constants of the branch/interrupt/decimal slice
`ifndef MBD_DEFINES_SVH
`define MBD_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets (low five address bits)
// ----------------------------------------------------------------
`define MBD_OFF_CMD     5'h00
`define MBD_OFF_STATUS  5'h04
`define MBD_OFF_ACC     5'h08
`define MBD_OFF_PC      5'h0C
`define MBD_OFF_PAGEHI  5'h10
`define MBD_OFF_TBLHI   5'h14
`define MBD_OFF_FSEL    5'h18
`define MBD_OFF_FDATA   5'h1C

// ----------------------------------------------------------------
// command word fields
// ----------------------------------------------------------------
`define MBD_CMD_OP      3:0
`define MBD_CMD_DEST    4
`define MBD_CMD_IDX     13:8
`define MBD_CMD_ADR     24:16

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define MBD_OP_DECADJ   4'h1
`define MBD_OP_DECSKIP  4'h2
`define MBD_OP_INTDIS   4'h3
`define MBD_OP_INTEN    4'h4
`define MBD_OP_JMP      4'h5
`define MBD_OP_CJMP     4'h6

// ----------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------
`define MBD_ST_BUSY     0
`define MBD_ST_CARRY    1
`define MBD_ST_GIE      2
`define MBD_ST_SKIP     3
`define MBD_ST_CYC      7:4

// ----------------------------------------------------------------
// constants and reset values
// ----------------------------------------------------------------
`define MBD_BCD_MAX     4'h9
`define MBD_ADJ_LO      9'h006
`define MBD_ADJ_HI      9'h060
`define MBD_CYC_ONE     4'h1
`define MBD_CYC_TWO     4'h2
`define MBD_RST_BYTE    8'h00
`define MBD_RST_PC      10'h000
`define MBD_RST_WORD    32'h0000_0000

`endif

// file: rtl/mbd_pkg.sv
// types shared by the branch/interrupt/decimal slice
package mbd_pkg;
	typedef enum logic [1:0] {
		MBD_IDLE,
		MBD_EXEC,
		MBD_FLUSH
	} mbd_state_e;
endpackage
